// ---- logic/fasm_map_top.sv ----
// flash address formation and sector map with an AHB-Lite register slave
// Behaviour
// - legacy commands keep taking three-byte addresses while the extended mode bit is clear.
// - in legacy form the upper address bits come from the bank register.
// - extended mode bit makes legacy commands expect four address bytes.
// - new commands always take a four-byte address.
// - reset clears bank register and selects three-byte addressing.
// - array decode ignores address bits 31 to 24.
// - separate address spaces decode the full 32-bit address.
// - second status register bit 7 picks hybrid or uniform sector layout.
// - bottom hybrid: sixteen 4 KB sectors low, then 255 of 64 KB.
// - top hybrid: 255 of 64 KB, then sixteen 4 KB sectors at top.
// - uniform layout: 64 sectors of 256 KB from address zero.
// - every sector is aligned to its own size.
module fasm_map_top #(
  parameter logic [31:0] ALT_SPACE_SIZE = 32'h0000_0400
) (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic [31:0]                      hrdata,
  output fasm_pkg::fasm_sector_s           sector,
  output logic [fasm_pkg::ADDR_W-1:0]      eff_addr,
  output logic                             alt_space,
  output logic                             alt_hit,
  output logic                             decode_valid
);

  // bus data phase tracking
  logic [7:0]  off_ff;
  logic [7:0]  nxt_off;
  logic        wr_ff;
  logic        nxt_wr;
  logic        act_ff;
  logic        nxt_act;
  logic        wr_bank;
  logic        wr_cfg;
  logic        wr_caddr;
  logic        wr_kind;

  // software registers
  logic [7:0]  bank_ff;
  logic [7:0]  nxt_bank;
  logic [7:0]  cfg_ff;
  logic [7:0]  nxt_cfg;
  logic [31:0] caddr_ff;
  logic [31:0] nxt_caddr;
  logic        wide_ff;
  logic        nxt_wide;
  logic        alt_ff;
  logic        nxt_alt;

  // decode state and results
  fasm_pkg::fasm_state_e  state_ff;
  fasm_pkg::fasm_state_e  nxt_state;
  fasm_pkg::fasm_sector_s sector_ff;
  fasm_pkg::fasm_sector_s nxt_sector;
  logic [31:0] eff_ff;
  logic [31:0] nxt_eff;
  logic        four_ff;
  logic        nxt_four;
  logic        alt_res_ff;
  logic        nxt_alt_res;
  logic        hit_ff;
  logic        nxt_hit;
  logic        done_ff;
  logic        nxt_done;
  logic        valid_ff;
  logic        nxt_valid;

  fasm_pkg::fasm_cmd_s    cmd;
  fasm_pkg::fasm_sector_s dec_sector;
  logic [31:0] form_addr;
  logic        form_four;

  assign hreadyout = 1'b1;
  assign hresp     = fasm_pkg::HRESP_OKAY;

  // bus: capture address phase, zero wait state slave
  always_comb begin
    nxt_act = hsel & hready & (htrans == fasm_pkg::HTRANS_NONSEQ);
    nxt_wr  = hwrite;
    nxt_off = haddr[7:0];
    if (!nxt_act) begin
      nxt_wr  = 1'b0;
      nxt_off = off_ff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_ff <= 1'b0;
      wr_ff  <= 1'b0;
      off_ff <= 8'h00;
    end else begin
      act_ff <= nxt_act;
      wr_ff  <= nxt_wr;
      off_ff <= nxt_off;
    end
  end

  assign wr_bank  = act_ff & wr_ff & (off_ff == fasm_pkg::OFF_BANK);
  assign wr_cfg   = act_ff & wr_ff & (off_ff == fasm_pkg::OFF_CFG);
  assign wr_caddr = act_ff & wr_ff & (off_ff == fasm_pkg::OFF_CMD_ADDR);
  assign wr_kind  = act_ff & wr_ff & (off_ff == fasm_pkg::OFF_CMD_KIND);

  // registers written by software
  always_comb begin
    nxt_bank  = bank_ff;
    nxt_cfg   = cfg_ff;
    nxt_caddr = caddr_ff;
    nxt_wide  = wide_ff;
    nxt_alt   = alt_ff;
    if (wr_bank) begin
      nxt_bank = hwdata[7:0];
    end
    if (wr_cfg) begin
      nxt_cfg = hwdata[7:0];
    end
    if (wr_caddr) begin
      nxt_caddr = hwdata;
    end
    if (wr_kind) begin
      nxt_wide = hwdata[fasm_pkg::KIND_WIDE_BIT];
      nxt_alt  = hwdata[fasm_pkg::KIND_ALT_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bank_ff  <= fasm_pkg::BANK_RST;
      cfg_ff   <= fasm_pkg::CFG_RST;
      caddr_ff <= fasm_pkg::WORD_RST;
      wide_ff  <= 1'b0;
      alt_ff   <= 1'b0;
    end else begin
      bank_ff  <= nxt_bank;
      cfg_ff   <= nxt_cfg;
      caddr_ff <= nxt_caddr;
      wide_ff  <= nxt_wide;
      alt_ff   <= nxt_alt;
    end
  end

  assign cmd.addr = caddr_ff;
  assign cmd.wide = wide_ff;
  assign cmd.alt  = alt_ff;

  fasm_addr_form u_form (
    .cmd       (cmd),
    .bank      (bank_ff),
    .eff_addr  (form_addr),
    .four_byte (form_four)
  );

  // only the low three bytes reach the array decode
  fasm_sector_dec u_dec (
    .array_addr (form_addr[fasm_pkg::ARRAY_AW-1:0]),
    .uniform    (cfg_ff[fasm_pkg::CFG_UNIF_BIT]),
    .top        (cfg_ff[fasm_pkg::CFG_TOP_BIT]),
    .sector     (dec_sector)
  );

  // decode sequencer: a kind write starts one decode, results held after
  always_comb begin
    nxt_state   = state_ff;
    nxt_sector  = sector_ff;
    nxt_eff     = eff_ff;
    nxt_four    = four_ff;
    nxt_alt_res = alt_res_ff;
    nxt_hit     = hit_ff;
    nxt_done    = done_ff;
    nxt_valid   = 1'b0;
    unique case (state_ff)
      fasm_pkg::ST_IDLE: begin
        if (wr_kind) begin
          nxt_state = fasm_pkg::ST_DEC;
          nxt_done  = 1'b0;
        end
      end
      fasm_pkg::ST_DEC: begin
        nxt_state   = fasm_pkg::ST_IDLE;
        nxt_eff     = form_addr;
        nxt_four    = form_four;
        nxt_alt_res = alt_ff;
        // separate spaces compare all 32 bits against their populated size
        nxt_hit     = alt_ff & (form_addr < ALT_SPACE_SIZE);
        nxt_sector  = dec_sector;
        nxt_done    = 1'b1;
        nxt_valid   = 1'b1;
      end
      default: begin
        nxt_state = fasm_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff   <= fasm_pkg::ST_IDLE;
      sector_ff  <= '0;
      eff_ff     <= fasm_pkg::WORD_RST;
      four_ff    <= 1'b0;
      alt_res_ff <= 1'b0;
      hit_ff     <= 1'b0;
      done_ff    <= 1'b0;
      valid_ff   <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      sector_ff  <= nxt_sector;
      eff_ff     <= nxt_eff;
      four_ff    <= nxt_four;
      alt_res_ff <= nxt_alt_res;
      hit_ff     <= nxt_hit;
      done_ff    <= nxt_done;
      valid_ff   <= nxt_valid;
    end
  end

  assign sector       = sector_ff;
  assign eff_addr     = eff_ff;
  assign alt_space    = alt_res_ff;
  assign alt_hit      = hit_ff;
  assign decode_valid = valid_ff;

  // read mux; unmapped offsets read as zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (act_ff && !wr_ff) begin
      unique case (off_ff)
        fasm_pkg::OFF_BANK: begin
          hrdata = {24'h00_0000, bank_ff};
        end
        fasm_pkg::OFF_CFG: begin
          hrdata = {24'h00_0000, cfg_ff};
        end
        fasm_pkg::OFF_CMD_ADDR: begin
          hrdata = caddr_ff;
        end
        fasm_pkg::OFF_CMD_KIND: begin
          hrdata[fasm_pkg::KIND_WIDE_BIT] = wide_ff;
          hrdata[fasm_pkg::KIND_ALT_BIT]  = alt_ff;
        end
        fasm_pkg::OFF_STATUS: begin
          hrdata[fasm_pkg::ST_BUSY_BIT]  = (state_ff == fasm_pkg::ST_DEC);
          hrdata[fasm_pkg::ST_DONE_BIT]  = done_ff;
          hrdata[fasm_pkg::ST_ADDR4_BIT] = form_four;
          hrdata[fasm_pkg::ST_ALT_BIT]   = alt_res_ff;
          hrdata[fasm_pkg::ST_HIT_BIT]   = hit_ff;
        end
        fasm_pkg::OFF_EFF_ADDR: begin
          hrdata = eff_ff;
        end
        fasm_pkg::OFF_SECTOR: begin
          hrdata[fasm_pkg::SEC_IDX_W-1:0]             = sector_ff.index;
          hrdata[fasm_pkg::SEC_SIZE_LSB+1:fasm_pkg::SEC_SIZE_LSB] = sector_ff.size;
        end
        fasm_pkg::OFF_SEC_BASE: begin
          hrdata = {8'h00, sector_ff.base};
        end
        default: begin
          hrdata = 32'h0000_0000;
        end
      endcase
    end
  end

endmodule

// ---- logic/fasm_pkg.sv ----
// package: constants, types and register map for the flash address and sector map block
package fasm_pkg;

  localparam int unsigned ADDR_W       = 32;
  localparam int unsigned ARRAY_AW     = 24;
  localparam int unsigned SEC_IDX_W    = 9;
  localparam int unsigned BANK_HI_W    = 7;

  // register byte offsets
  localparam logic [7:0] OFF_BANK      = 8'h00;
  localparam logic [7:0] OFF_CFG       = 8'h04;
  localparam logic [7:0] OFF_CMD_ADDR  = 8'h08;
  localparam logic [7:0] OFF_CMD_KIND  = 8'h0C;
  localparam logic [7:0] OFF_STATUS    = 8'h10;
  localparam logic [7:0] OFF_EFF_ADDR  = 8'h14;
  localparam logic [7:0] OFF_SECTOR    = 8'h18;
  localparam logic [7:0] OFF_SEC_BASE  = 8'h1C;

  // field positions
  localparam int unsigned BANK_EXT_BIT  = 7;
  localparam int unsigned CFG_UNIF_BIT  = 7;
  localparam int unsigned CFG_TOP_BIT   = 2;
  localparam int unsigned KIND_WIDE_BIT = 0;
  localparam int unsigned KIND_ALT_BIT  = 1;
  localparam int unsigned ST_BUSY_BIT   = 0;
  localparam int unsigned ST_DONE_BIT   = 1;
  localparam int unsigned ST_ADDR4_BIT  = 2;
  localparam int unsigned ST_ALT_BIT    = 3;
  localparam int unsigned ST_HIT_BIT    = 4;
  localparam int unsigned SEC_SIZE_LSB  = 16;

  // reset values
  localparam logic [7:0]  BANK_RST     = 8'h00;
  localparam logic [7:0]  CFG_RST      = 8'h00;
  localparam logic [31:0] WORD_RST     = 32'h0000_0000;

  // sector geometry
  localparam int unsigned SEC4K_SHIFT   = 12;
  localparam int unsigned SEC64K_SHIFT  = 16;
  localparam int unsigned SEC256K_SHIFT = 18;
  localparam int unsigned HYB_SMALL_CNT = 16;
  localparam int unsigned HYB_BIG_CNT   = 255;
  localparam int unsigned UNIF_CNT      = 64;
  localparam logic [7:0]  HYB_TOP_BLK   = 8'hFF;
  localparam logic [7:0]  HYB_BOT_BLK   = 8'h00;

  localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;
  localparam logic        HRESP_OKAY    = 1'b0;

  typedef enum logic [1:0] {
    SZ_4K   = 2'h0,
    SZ_64K  = 2'h1,
    SZ_256K = 2'h2
  } fasm_size_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DEC  = 2'b10
  } fasm_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              wide;
    logic              alt;
  } fasm_cmd_s;

  typedef struct packed {
    logic [SEC_IDX_W-1:0] index;
    fasm_size_e           size;
    logic [ARRAY_AW-1:0]  base;
  } fasm_sector_s;

endpackage

// ---- logic/fasm_addr_form.sv ----
// effective address formation from a command address and the bank register
module fasm_addr_form (
  input  wire fasm_pkg::fasm_cmd_s      cmd,
  input  wire logic [7:0]               bank,
  output logic [fasm_pkg::ADDR_W-1:0]   eff_addr,
  output logic                          four_byte
);

  always_comb begin
    // new commands always carry four bytes, legacy ones only in extended mode
    four_byte = cmd.wide | bank[fasm_pkg::BANK_EXT_BIT];
    if (four_byte) begin
      eff_addr = cmd.addr;
    end else begin
      // top bit of the upper byte is the mode flag, never an address bit
      eff_addr = {1'b0, bank[fasm_pkg::BANK_HI_W-1:0], cmd.addr[fasm_pkg::ARRAY_AW-1:0]};
    end
  end

endmodule

// ---- logic/fasm_sector_dec.sv ----
// sector index, size and base decode for hybrid and uniform layouts
module fasm_sector_dec (
  input  wire logic [fasm_pkg::ARRAY_AW-1:0] array_addr,
  input  wire logic                          uniform,
  input  wire logic                          top,
  output fasm_pkg::fasm_sector_s             sector
);

  logic [7:0] blk64;
  logic [3:0] sub4;

  assign blk64 = array_addr[fasm_pkg::ARRAY_AW-1:fasm_pkg::SEC64K_SHIFT];
  assign sub4  = array_addr[fasm_pkg::SEC64K_SHIFT-1:fasm_pkg::SEC4K_SHIFT];

  always_comb begin
    sector.index = '0;
    sector.size  = fasm_pkg::SZ_64K;
    sector.base  = {blk64, 16'h0000};
    if (uniform) begin
      sector.index = {3'b000, array_addr[fasm_pkg::ARRAY_AW-1:fasm_pkg::SEC256K_SHIFT]};
      sector.size  = fasm_pkg::SZ_256K;
      sector.base  = {array_addr[fasm_pkg::ARRAY_AW-1:fasm_pkg::SEC256K_SHIFT], 18'h0_0000};
    end else if (top) begin
      if (blk64 == fasm_pkg::HYB_TOP_BLK) begin
        sector.index = 9'(fasm_pkg::HYB_BIG_CNT) + {5'b0_0000, sub4};
        sector.size  = fasm_pkg::SZ_4K;
        sector.base  = {blk64, sub4, 12'h000};
      end else begin
        sector.index = {1'b0, blk64};
      end
    end else begin
      if (blk64 == fasm_pkg::HYB_BOT_BLK) begin
        sector.index = {5'b0_0000, sub4};
        sector.size  = fasm_pkg::SZ_4K;
        sector.base  = {blk64, sub4, 12'h000};
      end else begin
        sector.index = 9'(fasm_pkg::HYB_SMALL_CNT - 1) + {1'b0, blk64};
      end
    end
  end

endmodule

// ---- bench/fasm_host_model.sv ----
// bus master model standing in for the serial flash host controller
module fasm_host_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = '0;
  end

  // no shared data-3/reset line on this bus, so it is never pulled low
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input int gap,
                      output logic [31:0] q, output bit ok);
    int n;
    ok = 1'b0;
    repeat (gap + 1) @(posedge hclk);
    hsel <= 1'b1;
    htrans <= fasm_pkg::HTRANS_NONSEQ;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    for (n = 0; n < 20; n++) begin
      @(posedge hclk);
      if (hready === 1'b1) break;
    end
    if (n == 20) return;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge hclk);
      if (hready === 1'b1) break;
    end
    q = hrdata;
    // released data must not keep looking valid
    hwdata <= ~d;
    ok = (n < 20);
  endtask
endmodule

// ---- bench/fasm_map_checker.sv ----
// port assertions for the flash address and sector map block
module fasm_map_checker #(
  parameter logic [31:0] ALT_SPACE_SIZE = 32'h0000_0400
) (
  input wire logic                   hclk,
  input wire logic                   hresetn,
  input wire logic                   hsel,
  input wire logic [31:0]            haddr,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic                   hready,
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  input wire fasm_pkg::fasm_sector_s sector,
  input wire logic [31:0]            eff_addr,
  input wire logic                   alt_space,
  input wire logic                   alt_hit,
  input wire logic                   decode_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic kind_wr;
  assign kind_wr = hsel && hready && htrans == fasm_pkg::HTRANS_NONSEQ && hwrite
                   && haddr[7:0] == fasm_pkg::OFF_CMD_KIND;

  bus_okay_a: assert property (hreadyout && hresp == fasm_pkg::HRESP_OKAY)
    else $error("bus answer not ready or not okay");
  kind_start_a: assert property (kind_wr |-> ##1 !decode_valid ##1 !decode_valid ##1 decode_valid)
    else $error("decode did not follow command write");
  pulse_one_a: assert property (decode_valid |=> !decode_valid)
    else $error("decode pulse longer than one cycle");
  results_hold_a: assert property ($changed(eff_addr) || $changed(sector) |-> decode_valid)
    else $error("results changed without decode");
  sector_align_a: assert property (decode_valid |-> (sector.size == fasm_pkg::SZ_4K ? sector.base[11:0] == 12'h000 :
    sector.size == fasm_pkg::SZ_64K ? sector.base[15:0] == 16'h0000 : sector.base[17:0] == 18'h0_0000))
    else $error("sector base misaligned");
  base_cover_a: assert property (decode_valid |-> sector.base[23:18] == eff_addr[23:18])
    else $error("sector base does not cover address");
  uniform_idx_a: assert property (decode_valid && sector.size == fasm_pkg::SZ_256K |->
    sector.index == {3'b000, eff_addr[23:18]}) else $error("uniform index wrong");
  small_idx_a: assert property (decode_valid && sector.size == fasm_pkg::SZ_4K |->
    (eff_addr[23:16] == 8'h00 && sector.index == eff_addr[15:12])
    || (eff_addr[23:16] == 8'hFF && sector.index == 255 + eff_addr[15:12])) else $error("small index wrong");
  big_idx_a: assert property (decode_valid && sector.size == fasm_pkg::SZ_64K |->
    sector.index == eff_addr[23:16] || sector.index == eff_addr[23:16] + 15) else $error("big index wrong");
  alt_hit_a: assert property (decode_valid |-> alt_hit == (alt_space && eff_addr < ALT_SPACE_SIZE))
    else $error("separate space hit wrong");
endmodule

bind fasm_map_top fasm_map_checker #(.ALT_SPACE_SIZE(ALT_SPACE_SIZE)) u_chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hreadyout, .hresp, .sector, .eff_addr, .alt_space, .alt_hit, .decode_valid);

// ---- bench/tb_top.sv ----
// self-checking bench for the flash address and sector map block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, alt_space, alt_hit, decode_valid;
  logic [31:0]            haddr, hwdata, hrdata, eff_addr, q, r;
  logic [1:0]             htrans;
  logic [2:0]             hsize;
  fasm_pkg::fasm_sector_s sector;
  int                     err_count, compares;
  bit                     ok;
  logic [23:0]            bnd [8] = '{24'h00_0FFF, 24'h00_FFFF, 24'h01_0000, 24'h03_FFFF,
                                      24'h04_0000, 24'hFE_FFFF, 24'hFF_0000, 24'hFF_FFFF};
  logic [7:0]             cfgs [3] = '{8'h00, 8'h04, 8'h80};

  assign hready = hreadyout;
  always #2 hclk = ~hclk;

  fasm_map_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
                    .hresp, .hrdata, .sector, .eff_addr, .alt_space, .alt_hit, .decode_valid);
  fasm_host_model host (.hclk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);

  task final_report;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task cmp(input logic [63:0] g, input logic [63:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    host.xfer(w, a, d, $urandom_range(2, 0), q, ok);
    if (!ok) begin
      err_count++;
      final_report();
    end
  endtask

  function automatic logic [34:0] secx(logic [23:0] a, logic [7:0] c);
    int i, s, sh;
    if (c[7]) begin
      s = 2;
      i = a >> 18;
    end else if (!c[2]) begin
      s = (a < 'h1_0000) ? 0 : 1;
      i = (s == 0) ? (a >> 12) : 15 + (a >> 16);
    end else begin
      s = (a >= 'hFF_0000) ? 0 : 1;
      i = (s == 0) ? 255 + ((a >> 12) & 15) : (a >> 16);
    end
    sh = (s == 0) ? 12 : (s == 1) ? 16 : 18;
    return {i[8:0], s[1:0], (a >> sh) << sh};
  endfunction

  task dec(input logic [31:0] a, input logic [7:0] b, input logic [7:0] c, input logic [1:0] k);
    logic [31:0] e;
    int n;
    // only new commands or extended mode carry four bytes; separate spaces still use the bank bits
    e = (k[0] || b[7]) ? a : {1'b0, b[6:0], a[23:0]};
    acc(1'b1, fasm_pkg::OFF_BANK, {24'h00_0000, b});
    acc(1'b1, fasm_pkg::OFF_CFG, {24'h00_0000, c});
    acc(1'b1, fasm_pkg::OFF_CMD_ADDR, a);
    acc(1'b1, fasm_pkg::OFF_CMD_KIND, {30'h0, k});
    n = 0;
    while (decode_valid !== 1'b1 && n < 5) begin
      @(posedge hclk);
      #1;
      n++;
    end
    if (n == 5) begin
      err_count++;
      final_report();
    end
    cmp(eff_addr, e);
    cmp(sector, secx(e[23:0], c));
    cmp({alt_space, alt_hit}, {k[1], k[1] && e < 32'h0000_0400});
    acc(1'b0, fasm_pkg::OFF_EFF_ADDR, '0);
    cmp(q, e);
    acc(1'b0, fasm_pkg::OFF_STATUS, '0);
    cmp(q, {27'h000_0000, k[1] && e < 32'h0000_0400, k[1], k[0] || b[7], 2'b10});
  endtask

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    err_count = 0;
    compares = 0;
    void'($urandom(69750));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    acc(1'b0, fasm_pkg::OFF_BANK, '0);
    cmp(q, 0);
    acc(1'b0, 8'h40, '0);
    cmp(q, 0);
    dec(32'hAB12_3456, 8'h05, 8'h00, 2'd0);
    dec(32'hAB12_3456, 8'h85, 8'h04, 2'd0);
    dec(32'h7F12_3456, 8'h05, 8'h80, 2'd1);
    dec(32'h0000_03FF, 8'h00, 8'h00, 2'd2);
    dec(32'h0100_0400, 8'h05, 8'h00, 2'd3);
    foreach (cfgs[c])
      foreach (bnd[i])
        dec({8'($urandom_range(255, 0)), bnd[i]}, 8'h00, cfgs[c], 2'd1);
    repeat (40) begin
      r = $urandom;
      dec($urandom, r[7:0], {r[8], 5'b0, r[9], 2'b0}, r[11:10]);
    end
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    acc(1'b0, fasm_pkg::OFF_BANK, '0);
    cmp(q, 0);
    acc(1'b0, fasm_pkg::OFF_CFG, '0);
    cmp(q, 0);
    cmp(eff_addr, 0);
    final_report();
  end
endmodule
